// File: rtl/hdcr_consts.vh
// Register map, field positions and reset values of the haptic drive configuration bank
`ifndef HDCR_CONSTS_VH
`define HDCR_CONSTS_VH

`define HDCR_ADDR_W          8
`define HDCR_OFS_UNLOCK      8'h10
`define HDCR_OFS_FULL_SCALE  8'h12
`define HDCR_OFS_SUPPLY_TH   8'h13
`define HDCR_OFS_SKIP_TH     8'h14
`define HDCR_OFS_RESTORE_DLY 8'h15
`define HDCR_OFS_STATUS      8'h1f

`define HDCR_UNLOCK_BIT      0
`define HDCR_RESTORE_BIT     7
`define HDCR_SKIP_W          7
`define HDCR_DLY_W           5
`define HDCR_GUESS_W         12

`define HDCR_RST_FULL_SCALE  8'hff
`define HDCR_RST_SUPPLY_TH   8'h00
`define HDCR_RST_SKIP_TH     7'h00
`define HDCR_RST_DLY         5'h00
`define HDCR_RST_RESTORE     1'b0

`endif

// File: rtl/hdcr_haptic_drive_config_regs.v
// Haptic drive configuration bank with supply lock, skip and guess restore logic
//
// Summary of operation
// R01: Amplitude percentage is referred to an 8-bit full-scale voltage code.
// R02: Effective full scale is min of programmed code and supply code.
// R03: Supply below threshold locks driver, pulses interrupt, sets fault flag.
// R04: Lock holds until software writes 1 to the unlock bit.
// R05: Skip back-EMF detection when amplitude magnitude is below skip threshold.
// R06: Restore-disable 0 reloads initial guess after braking half periods end.
// R07: Restore-disable 1 keeps present frequency after braking ends.
// R08: Wait programmed half periods before starting or restarting measurement.
// R09: Unlock bit returns to zero by itself after the unlock.
// R10: Supply compared continuously on threshold scale while driver enabled.
`timescale 1ns/1ps
`include "hdcr_consts.vh"

module hdcr_haptic_drive_config_regs (
  input  wire        i_sys_clk,        // System clock, 50 MHz
  input  wire        i_reset,          // Synchronous reset, active high
  input  wire        i_wr_en,          // Register write strobe
  input  wire        i_rd_en,          // Register read strobe
  input  wire [7:0]  i_addr,           // Register offset
  input  wire [7:0]  i_wdata,          // Write data
  output reg  [7:0]  o_rdata,          // Read data, registered
  input  wire        i_driver_enable,  // Driver enable request from playback
  input  wire [7:0]  i_supply_code,    // Digitized driver supply, 21.57 mV steps
  input  wire [7:0]  i_amplitude,      // Signed amplitude, percent of full scale
  input  wire        i_half_period,    // Pulse at each sinewave half period
  input  wire        i_pattern_start,  // Pulse at vibration pattern start
  input  wire        i_polarity_chg,   // Pulse at output polarity change
  input  wire        i_brake_done,     // Pulse when braking half periods end
  input  wire [11:0] i_initial_guess,  // Initial frequency guess
  input  wire [11:0] i_track_freq,     // Frequency from resonance tracking
  output reg  [7:0]  o_full_scale_eff, // Effective full-scale voltage code
  output reg         o_driver_run,     // Driver allowed to run
  output reg         o_supply_disable_irq, // One-cycle supply-disable interrupt
  output reg         o_driver_fault_flag,  // Sticky supply fault
  output reg         o_emf_skip,       // Back-EMF detection skipped
  output reg         o_emf_measure_en, // Back-EMF measurement allowed
  output reg  [11:0] o_drive_freq      // Driving frequency
);

  reg [7:0]                 full_scale_voltage_r;
  reg [7:0]                 supply_disable_threshold_r;
  reg [`HDCR_SKIP_W-1:0]    emf_skip_threshold_r;
  reg [`HDCR_DLY_W-1:0]     initial_measure_delay_r;
  reg                       guess_restore_disable_r;
  reg                       fault_unlock_bit_r;
  reg [`HDCR_DLY_W-1:0]     delay_cnt_r;
  reg                       skip_prev_r;

  wire wr_unlock  = i_wr_en && (i_addr == `HDCR_OFS_UNLOCK);
  wire wr_fs      = i_wr_en && (i_addr == `HDCR_OFS_FULL_SCALE);
  wire wr_th      = i_wr_en && (i_addr == `HDCR_OFS_SUPPLY_TH);
  wire wr_skip    = i_wr_en && (i_addr == `HDCR_OFS_SKIP_TH);
  wire wr_rd      = i_wr_en && (i_addr == `HDCR_OFS_RESTORE_DLY);
  wire undervolt  = i_driver_enable && (i_supply_code < supply_disable_threshold_r); // R10
  wire [`HDCR_SKIP_W-1:0] amp_mag = i_amplitude[`HDCR_SKIP_W-1:0];
  wire skip_now   = amp_mag < emf_skip_threshold_r; // R05
  // Any restart event reloads the wait count
  wire restart    = i_pattern_start || i_polarity_chg || (skip_prev_r && !skip_now); // R08

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      full_scale_voltage_r       <= `HDCR_RST_FULL_SCALE;
      supply_disable_threshold_r <= `HDCR_RST_SUPPLY_TH;
      emf_skip_threshold_r       <= `HDCR_RST_SKIP_TH;
      initial_measure_delay_r    <= `HDCR_RST_DLY;
      guess_restore_disable_r    <= `HDCR_RST_RESTORE;
    end else begin
      if (wr_fs)
        full_scale_voltage_r <= i_wdata; // R01
      if (wr_th)
        supply_disable_threshold_r <= i_wdata;
      if (wr_skip)
        emf_skip_threshold_r <= i_wdata[`HDCR_SKIP_W-1:0];
      if (wr_rd) begin
        initial_measure_delay_r <= i_wdata[`HDCR_DLY_W-1:0];
        guess_restore_disable_r <= i_wdata[`HDCR_RESTORE_BIT];
      end
    end
  end

  // Fault set wins over unlock so a fresh undervoltage is never lost
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_driver_fault_flag  <= 1'b0;
      o_supply_disable_irq <= 1'b0;
      fault_unlock_bit_r   <= 1'b0;
    end else begin
      o_supply_disable_irq <= undervolt && !o_driver_fault_flag; // R03
      if (undervolt)
        o_driver_fault_flag <= 1'b1; // R03
      else if (fault_unlock_bit_r)
        o_driver_fault_flag <= 1'b0; // R04
      if (wr_unlock && i_wdata[`HDCR_UNLOCK_BIT])
        fault_unlock_bit_r <= 1'b1;
      else
        fault_unlock_bit_r <= 1'b0; // R09
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_full_scale_eff <= 8'h00;
      o_driver_run     <= 1'b0;
      o_emf_skip       <= 1'b0;
      skip_prev_r      <= 1'b0;
      delay_cnt_r      <= `HDCR_RST_DLY;
      o_emf_measure_en <= 1'b0;
      o_drive_freq     <= 12'h000;
    end else begin
      o_full_scale_eff <= (full_scale_voltage_r < i_supply_code) ?
                          full_scale_voltage_r : i_supply_code; // R02
      o_driver_run     <= i_driver_enable && !o_driver_fault_flag && !undervolt; // R03 R04
      o_emf_skip       <= skip_now; // R05
      skip_prev_r      <= skip_now;
      if (restart) begin
        delay_cnt_r      <= initial_measure_delay_r; // R08
        o_emf_measure_en <= 1'b0;
      end else if (i_half_period && delay_cnt_r != 5'h00) begin
        delay_cnt_r      <= delay_cnt_r - 5'h01; // R08
        o_emf_measure_en <= 1'b0;
      end else begin
        o_emf_measure_en <= (delay_cnt_r == 5'h00) && !skip_now; // R05 R08
      end
      if (i_brake_done && !guess_restore_disable_r)
        o_drive_freq <= i_initial_guess; // R06
      else if (!i_brake_done)
        o_drive_freq <= i_track_freq;
      // Restore disabled: brake end holds present frequency
      else
        o_drive_freq <= o_drive_freq; // R07
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_reset)
      o_rdata <= 8'h00;
    else if (i_rd_en) begin
      case (i_addr)
        `HDCR_OFS_UNLOCK:      o_rdata <= {7'h00, fault_unlock_bit_r};
        `HDCR_OFS_FULL_SCALE:  o_rdata <= full_scale_voltage_r;
        `HDCR_OFS_SUPPLY_TH:   o_rdata <= supply_disable_threshold_r;
        `HDCR_OFS_SKIP_TH:     o_rdata <= {1'b0, emf_skip_threshold_r};
        `HDCR_OFS_RESTORE_DLY: o_rdata <= {guess_restore_disable_r, 2'b00,
                                           initial_measure_delay_r};
        `HDCR_OFS_STATUS:      o_rdata <= {5'h00, o_emf_skip, o_driver_run,
                                           o_driver_fault_flag};
        default:               o_rdata <= 8'h00;
      endcase
    end
  end

endmodule // hdcr_haptic_drive_config_regs

// File: tb/hdcr_chk.sv
// Protocol checker for the haptic drive configuration bank
`timescale 1ns/1ps
module hdcr_chk (
  input wire        i_sys_clk, i_reset, i_wr_en, i_driver_enable, i_brake_done,
  input wire [7:0]  i_addr, i_wdata, i_supply_code, o_full_scale_eff,
  input wire [11:0] i_initial_guess, o_drive_freq,
  input wire        o_driver_run, o_supply_disable_irq, o_driver_fault_flag
);
  // Shadows of the threshold, restore-disable and unlock fields the assertions use
  logic [7:0] th_r;
  logic       dis_r, unl_r;
  always @(posedge i_sys_clk)
    if (i_reset) begin
      th_r <= 8'h00; dis_r <= 1'b0; unl_r <= 1'b0;
    end else begin
      unl_r <= i_wr_en && i_addr == 8'h10 && i_wdata[0];
      if (i_wr_en && i_addr == 8'h13) th_r <= i_wdata;
      if (i_wr_en && i_addr == 8'h15) dis_r <= i_wdata[7];
    end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_full_scale_clamp: assert property (o_full_scale_eff <= $past(i_supply_code))
    else $error("full scale above supply");
  a_undervolt_sets_flag: assert property (i_driver_enable && i_supply_code < th_r
    |=> o_driver_fault_flag) else $error("fault flag not set");
  a_irq_on_entry: assert property (o_supply_disable_irq |->
    o_driver_fault_flag && !$past(o_driver_fault_flag)) else $error("stray irq");
  a_irq_one_cycle: assert property (o_supply_disable_irq |=> !o_supply_disable_irq)
    else $error("irq too long");
  a_flag_rise_irq: assert property ($rose(o_driver_fault_flag) |-> o_supply_disable_irq)
    else $error("no irq");
  a_flag_needs_unlock: assert property ($fell(o_driver_fault_flag) |-> $past(unl_r))
    else $error("flag cleared without unlock");
  a_fault_stops_run: assert property (o_driver_fault_flag |-> !o_driver_run)
    else $error("run while locked");
  a_run_needs_enable: assert property (o_driver_run |-> $past(i_driver_enable))
    else $error("run without enable");
  a_guess_restore: assert property (i_brake_done && !dis_r |=>
    o_drive_freq == $past(i_initial_guess)) else $error("guess not reloaded");
  a_guess_keep: assert property (i_brake_done && dis_r |=> $stable(o_drive_freq))
    else $error("frequency changed");
  c_lock: cover property (o_supply_disable_irq);
  c_unlock: cover property ($fell(o_driver_fault_flag));
  c_keep: cover property (i_brake_done && dis_r);
endmodule // hdcr_chk
bind hdcr_haptic_drive_config_regs hdcr_chk u_chk (.*);

// File: tb/tb.sv
// Self-checking bench for the haptic drive configuration bank
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, we = 0, re = 0, en = 0, hp = 0, ps = 0, bd = 0, run, irq, flag;
  logic pc = 0;
  logic [7:0] ad = 0, wd = 0, sup = 8'hff, amp = 0, r, th, st, fs, eff;
  logic [11:0] gs = 0, tf = 0, freq;
  logic skip, meas;
  int errors = 0, n_tests = 0, i;
  always #10 clk = ~clk;
  hdcr_haptic_drive_config_regs DUT (.i_sys_clk(clk), .i_reset(rst), .i_wr_en(we),
    .i_rd_en(re), .i_addr(ad), .i_wdata(wd), .o_rdata(r), .i_driver_enable(en),
    .i_supply_code(sup), .i_amplitude(amp), .i_half_period(hp), .i_pattern_start(ps),
    .i_polarity_chg(pc), .i_brake_done(bd), .i_initial_guess(gs), .i_track_freq(tf),
    .o_full_scale_eff(eff), .o_driver_run(run), .o_supply_disable_irq(irq),
    .o_driver_fault_flag(flag), .o_emf_skip(skip), .o_emf_measure_en(meas),
    .o_drive_freq(freq));
  function [7:0] clamp(input [7:0] a, b);
    return a < b ? a : b;
  endfunction
  task cyc; @(posedge clk); #1; endtask
  task chk(input [11:0] g, e);
    n_tests++;
    if (g !== e) begin errors++; $display("mismatch %0t got %h exp %h", $time, g, e); end
  endtask
  // Idle cycle after each access so back-to-back calls never re-raise a strobe in one step
  task wr(input [7:0] a, d); ad = a; wd = d; we = 1; cyc; we = 0; cyc; endtask
  task rd(input [7:0] a, e); ad = a; re = 1; cyc; re = 0; chk(r, e); cyc; endtask
  task end_sim;
    $display("errors=%0d tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin #400000; errors++; end_sim; end
  initial begin
    void'($urandom(23));
    repeat (10) cyc;
    rst = 0;
    rd(8'h12, 8'hff);
    rd(8'h30, 8'h00);
    th = $urandom_range(200, 20); wr(8'h13, th); rd(8'h13, th);
    fs = $urandom; wr(8'h12, fs); sup = $urandom; cyc; cyc;
    chk(eff, clamp(fs, sup));
    en = 1; sup = th - 1; cyc;
    chk({irq, flag, run}, 3'b110);
    sup = 8'hff; cyc; cyc; chk(flag, 1);
    wr(8'h10, 8'h01); cyc; chk(flag, 0);
    rd(8'h10, 8'h00); chk(run, 1);
    for (i = 0; i < 20; i++) begin
      st = $urandom; wr(8'h14, st); amp = i == 0 ? st : $urandom; cyc;
      chk(skip, amp[6:0] < st[6:0]);
    end
    for (i = 0; i < 2; i++) begin
      wr(8'h15, {i[0], 7'h00}); tf = $urandom; cyc; gs = $urandom; bd = 1; cyc; bd = 0;
      chk(freq, i ? tf : gs);
    end
    wr(8'h14, 8'h00); wr(8'h15, 8'h02); rd(8'h15, 8'h02);
    ps = 1; cyc; ps = 0; hp = 1; cyc; cyc; hp = 0;
    chk(meas, 0);
    cyc; chk(meas, 1);
    pc = 1; cyc; pc = 0;
    chk(meas, 0);
    rd(8'h1f, 8'h02);
    end_sim;
  end
endmodule // tb
